// *** design/ctsd_pkg.sv ***
// Constants for the continuous serial-number-and-data reader command path.
// Assumes byte streams from a UART and a tag front end on the core clock.
//
// Overview of operation
// - While continuous mode runs, no other host command is executed.
// - Packets open with 02H 02H and a payload-only two-byte size.
// - Two-byte read length follows; that many data bytes are read per tag.
// - Start/stop byte 01H enters continuous mode, 00H leaves it.
// - In continuous mode, wait for a tag in RF range before reading.
// - Accepted start answers size 01H, echo 0FH, then terminator.
// - Each tag gives echo 0EH, eight serial bytes, data; size counts all.
// - Identical tag withheld until out of range for delay seconds; zero sends all.
// - Any other command during continuous mode gets error reply 0FH.
package ctsd_pkg;
  localparam logic [7:0]  HDR_BYTE      = 8'h02;
  localparam logic [7:0]  ETX_BYTE      = 8'h03;
  localparam logic [7:0]  TRM_FF_BYTE   = 8'hff;
  localparam logic [7:0]  CMD_CONT      = 8'h0f;
  localparam logic [7:0]  ECHO_CONT     = 8'h0f;
  localparam logic [7:0]  ECHO_TAG      = 8'h0e;
  localparam logic [7:0]  ERR_CODE      = 8'h0f;
  localparam logic [7:0]  SS_START      = 8'h01;
  localparam logic [7:0]  SS_STOP       = 8'h00;
  localparam logic [15:0] SIZE_SHORT    = 16'h0001;
  localparam logic [15:0] SERIAL_BYTES  = 16'h0008;
  // Payload offsets of the continuous command
  localparam int          P_CODE        = 0;
  localparam int          P_ADDR_HI     = 1;
  localparam int          P_ADDR_LO     = 2;
  localparam int          P_LEN_HI      = 3;
  localparam int          P_LEN_LO      = 4;
  localparam int          P_DELAY       = 5;
  localparam int          P_STARTSTOP   = 6;
  localparam int          MAX_PAYLOAD   = 8;
  // Output packet byte positions
  localparam logic [4:0]  IX_SZ_HI      = 5'h02;
  localparam logic [4:0]  IX_SZ_LO      = 5'h03;
  localparam logic [4:0]  IX_ECHO       = 5'h04;
  localparam logic [4:0]  IX_SERIAL0    = 5'h05;
  // Last serial byte slot; the header is 13 bytes long
  localparam logic [4:0]  IX_SERIAL_END = 5'h0c;
  localparam logic [4:0]  IX_SHORT_END  = 5'h05;
  localparam logic [5:0]  DELAY_MAX_S   = 6'h3c;
  localparam longint      CLK_PERIOD_NS = 100;
  localparam longint      SECOND_NS     = 1000000000;
  localparam longint      SECOND_CYC    = SECOND_NS / CLK_PERIOD_NS;
  typedef enum logic [2:0] {PS_H1, PS_H2, PS_SZH, PS_SZL, PS_PAY, PS_TRM, PS_TRM2, PS_HOLD}
    ctsd_parse_e;
  typedef enum logic [2:0] {ST_IDLE, ST_SHORT, ST_WAIT, ST_HEAD, ST_DATA, ST_TERM}
    ctsd_state_e;
endpackage

// *** design/ctsd_parser.sv ***
// Host packet parser: frames bytes into a command payload.
// Assumes rx bytes come from a UART on core_clk_i, one per valid cycle.
`timescale 1ns/1ns
`default_nettype none
module ctsd_parser #(
  parameter int MAX_PAY = ctsd_pkg::MAX_PAYLOAD
) (
  input  wire logic                 core_clk_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 rx_valid_i,
  input  wire logic [7:0]           rx_data_i,
  output logic                      rx_ready_o,
  output logic                      cmd_valid_o,
  input  wire logic                 cmd_take_i,
  output logic [MAX_PAY*8-1:0]      cmd_bytes_o
);
  initial begin
    if (MAX_PAY < 7 || MAX_PAY > 255) $error("MAX_PAY out of range");
  end

  ctsd_pkg::ctsd_parse_e st_r;
  logic [15:0]           size_r;
  logic [15:0]           cnt_r;
  logic                  chk_seen_r;
  logic [7:0]            buf_r [MAX_PAY];
  wire                   take_byte = rx_valid_i && rx_ready_o;
  wire                   last_pay  = (cnt_r + 16'h0001) == size_r;

  assign rx_ready_o  = (st_r != ctsd_pkg::PS_HOLD);
  assign cmd_valid_o = (st_r == ctsd_pkg::PS_HOLD);

  ////////////////////////////////////////////////////////////////////////
  genvar gi;
  generate
    for (gi = 0; gi < MAX_PAY; gi++) begin : g_buf
      assign cmd_bytes_o[gi*8 +: 8] = buf_r[gi];
      always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          buf_r[gi] <= 8'h00;
        end else if (take_byte && st_r == ctsd_pkg::PS_PAY && cnt_r == 16'(gi)) begin
          buf_r[gi] <= rx_data_i;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r       <= ctsd_pkg::PS_H1;
      size_r     <= 16'h0000;
      cnt_r      <= 16'h0000;
      chk_seen_r <= 1'b0;
    end else if (st_r == ctsd_pkg::PS_HOLD) begin
      if (cmd_take_i) begin
        st_r <= ctsd_pkg::PS_H1;
      end
    end else if (take_byte) begin
      unique case (st_r)
        ctsd_pkg::PS_H1: begin
          if (rx_data_i == ctsd_pkg::HDR_BYTE) st_r <= ctsd_pkg::PS_H2;
        end
        ctsd_pkg::PS_H2: begin
          st_r <= (rx_data_i == ctsd_pkg::HDR_BYTE) ? ctsd_pkg::PS_SZH : ctsd_pkg::PS_H1;
        end
        ctsd_pkg::PS_SZH: begin
          size_r[15:8] <= rx_data_i;
          st_r         <= ctsd_pkg::PS_SZL;
        end
        ctsd_pkg::PS_SZL: begin
          size_r[7:0] <= rx_data_i;
          cnt_r       <= 16'h0000;
          chk_seen_r  <= 1'b0;
          st_r        <= ({size_r[15:8], rx_data_i} == 16'h0000) ? ctsd_pkg::PS_TRM
                                                                  : ctsd_pkg::PS_PAY;
        end
        ctsd_pkg::PS_PAY: begin
          cnt_r <= cnt_r + 16'h0001;
          if (last_pay) st_r <= ctsd_pkg::PS_TRM;
        end
        ctsd_pkg::PS_TRM: begin
          if (rx_data_i == ctsd_pkg::ETX_BYTE) begin
            st_r <= ctsd_pkg::PS_HOLD;
          end else if (rx_data_i == ctsd_pkg::TRM_FF_BYTE) begin
            st_r <= ctsd_pkg::PS_TRM2;
          end else if (!chk_seen_r) begin
            chk_seen_r <= 1'b1;
          end else begin
            st_r <= ctsd_pkg::PS_H1;
          end
        end
        ctsd_pkg::PS_TRM2: begin
          st_r <= (rx_data_i == ctsd_pkg::TRM_FF_BYTE) ? ctsd_pkg::PS_HOLD : ctsd_pkg::PS_H1;
        end
        default: st_r <= ctsd_pkg::PS_H1;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** design/ctsd_top.sv ***
// Continuous serial-number-and-data read command interpreter.
// Assumes host bytes, tag presence and tag bytes all arrive on core_clk_i.
`timescale 1ns/1ns
`default_nettype none
module ctsd_top #(
  parameter longint SEC_CYCLES = ctsd_pkg::SECOND_CYC,
  parameter int     MAX_PAY    = ctsd_pkg::MAX_PAYLOAD
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        rx_valid_i,
  input  wire logic [7:0]  rx_data_i,
  output logic             rx_ready_o,
  output logic             tx_valid_o,
  output logic [7:0]       tx_data_o,
  input  wire logic        tx_ready_i,
  input  wire logic        tag_present_i,
  input  wire logic [63:0] tag_serial_number_i,
  output logic             tag_rd_req_o,
  output logic [15:0]      tag_rd_addr_o,
  output logic [15:0]      tag_rd_len_o,
  input  wire logic        tag_byte_valid_i,
  input  wire logic [7:0]  tag_byte_i,
  output logic             tag_byte_ready_o,
  output logic             cont_active_o,
  output logic             other_cmd_valid_o,
  output logic [7:0]       other_cmd_code_o
);
  initial begin
    if (SEC_CYCLES < 1 || SEC_CYCLES > 64'h0000_0000_ffff_ffff) $error("SEC_CYCLES bad");
  end

  ////////////////////////////////////////////////////////////////////////
  // Command intake
  logic                 cmd_valid;
  logic [MAX_PAY*8-1:0] cmd_bytes;
  logic                 cmd_take;

  ctsd_parser #(.MAX_PAY(MAX_PAY)) u_parser (
    .core_clk_i  (core_clk_i),
    .rst_n_i     (rst_n_i),
    .rx_valid_i  (rx_valid_i),
    .rx_data_i   (rx_data_i),
    .rx_ready_o  (rx_ready_o),
    .cmd_valid_o (cmd_valid),
    .cmd_take_i  (cmd_take),
    .cmd_bytes_o (cmd_bytes)
  );

  wire [7:0] cmd_code = cmd_bytes[ctsd_pkg::P_CODE*8 +: 8];
  wire       is_cont  = (cmd_code == ctsd_pkg::CMD_CONT);
  wire [7:0] ss_byte  = cmd_bytes[ctsd_pkg::P_STARTSTOP*8 +: 8];
  wire       is_start = is_cont && (ss_byte == ctsd_pkg::SS_START);
  wire       is_stop  = is_cont && (ss_byte == ctsd_pkg::SS_STOP);

  ////////////////////////////////////////////////////////////////////////
  // State
  ctsd_pkg::ctsd_state_e st_r;
  logic                  active_r;
  logic [15:0]           addr_r;
  logic [15:0]           len_r;
  logic [5:0]            delay_r;
  logic [15:0]           size_r;
  logic [7:0]            echo_r;
  logic [4:0]            idx_r;
  logic [15:0]           dcnt_r;
  logic [63:0]           serial_r;
  logic [63:0]           last_serial_r;
  logic                  last_vld_r;
  logic [31:0]           sec_cnt_r;
  logic [5:0]            away_s_r;
  logic                  tx_valid_r;
  logic [7:0]            tx_data_r;
  logic                  rd_req_r;
  logic                  oth_vld_r;
  logic [7:0]            oth_code_r;

  wire can_emit = !tx_valid_r || tx_ready_i;
  wire in_ctl   = (st_r == ctsd_pkg::ST_IDLE) || (st_r == ctsd_pkg::ST_WAIT);
  // commands only taken in ST_IDLE or ST_WAIT, never while a reply packet is being sent
  assign cmd_take = cmd_valid && in_ctl;

  // same tag held back until away long enough
  wire suppress  = last_vld_r && (tag_serial_number_i == last_serial_r) && (delay_r != 6'h00);
  // read only with a tag in range
  wire tag_go    = (st_r == ctsd_pkg::ST_WAIT) && !cmd_valid && tag_present_i && !suppress;
  wire short_end = (idx_r == ctsd_pkg::IX_SHORT_END);
  wire head_end  = (idx_r == ctsd_pkg::IX_SERIAL_END);
  wire data_go   = (st_r == ctsd_pkg::ST_DATA) && (dcnt_r != len_r);
  wire [2:0] serial_ix = 3'(idx_r - ctsd_pkg::IX_SERIAL0);

  // Byte selection for the packet being built
  wire [7:0] serial_byte = serial_r[63 - {serial_ix, 3'b000} -: 8];
  wire [7:0] head_byte =
      (idx_r == ctsd_pkg::IX_SZ_HI) ? size_r[15:8] :
      (idx_r == ctsd_pkg::IX_SZ_LO) ? size_r[7:0] :
      (idx_r == ctsd_pkg::IX_ECHO)  ? echo_r :
      (idx_r >= ctsd_pkg::IX_SERIAL0) ? serial_byte : ctsd_pkg::HDR_BYTE;
  wire [7:0] short_byte = short_end ? ctsd_pkg::ETX_BYTE : head_byte;

  assign tag_byte_ready_o  = data_go && can_emit;
  assign tx_valid_o        = tx_valid_r;
  assign tx_data_o         = tx_data_r;
  assign tag_rd_req_o      = rd_req_r;
  assign tag_rd_addr_o     = addr_r;
  assign tag_rd_len_o      = len_r;
  assign cont_active_o     = active_r;
  assign other_cmd_valid_o = oth_vld_r;
  assign other_cmd_code_o  = oth_code_r;

  ////////////////////////////////////////////////////////////////////////
  // Control sequencer
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r       <= ctsd_pkg::ST_IDLE;
      active_r   <= 1'b0;
      addr_r     <= 16'h0000;
      len_r      <= 16'h0000;
      delay_r    <= 6'h00;
      size_r     <= 16'h0000;
      echo_r     <= 8'h00;
      idx_r      <= 5'h00;
      dcnt_r     <= 16'h0000;
      serial_r   <= 64'h0;
      rd_req_r   <= 1'b0;
      oth_vld_r  <= 1'b0;
      oth_code_r <= 8'h00;
    end else begin
      rd_req_r  <= 1'b0;
      oth_vld_r <= 1'b0;
      unique case (st_r)
        ctsd_pkg::ST_IDLE, ctsd_pkg::ST_WAIT: begin
          idx_r  <= 5'h00;
          dcnt_r <= 16'h0000;
          if (cmd_take) begin
            size_r <= ctsd_pkg::SIZE_SHORT;
            if (is_start || is_stop) begin
              addr_r   <= {cmd_bytes[ctsd_pkg::P_ADDR_HI*8 +: 8],
                           cmd_bytes[ctsd_pkg::P_ADDR_LO*8 +: 8]};
              len_r    <= {cmd_bytes[ctsd_pkg::P_LEN_HI*8 +: 8],
                           cmd_bytes[ctsd_pkg::P_LEN_LO*8 +: 8]};
              delay_r  <= (cmd_bytes[ctsd_pkg::P_DELAY*8 +: 8] > 8'(ctsd_pkg::DELAY_MAX_S))
                          ? ctsd_pkg::DELAY_MAX_S : cmd_bytes[ctsd_pkg::P_DELAY*8 +: 6];
              active_r <= is_start;
              echo_r   <= ctsd_pkg::ECHO_CONT;
              st_r     <= ctsd_pkg::ST_SHORT;
            end else if (st_r == ctsd_pkg::ST_WAIT || is_cont) begin
              echo_r <= ctsd_pkg::ERR_CODE;
              st_r   <= ctsd_pkg::ST_SHORT;
            end else begin
              oth_vld_r  <= 1'b1;
              oth_code_r <= cmd_code;
            end
          end else if (tag_go) begin
            // size is echo plus serial plus data
            serial_r <= tag_serial_number_i;
            size_r   <= 16'(len_r + ctsd_pkg::SERIAL_BYTES + 16'h0001);
            echo_r   <= ctsd_pkg::ECHO_TAG;
            rd_req_r <= 1'b1;
            st_r     <= ctsd_pkg::ST_HEAD;
          end
        end
        ctsd_pkg::ST_SHORT: begin
          if (can_emit) begin
            idx_r <= idx_r + 5'h01;
            if (short_end) st_r <= active_r ? ctsd_pkg::ST_WAIT : ctsd_pkg::ST_IDLE;
          end
        end
        ctsd_pkg::ST_HEAD: begin
          if (can_emit) begin
            idx_r <= idx_r + 5'h01;
            if (head_end) st_r <= ctsd_pkg::ST_DATA;
          end
        end
        ctsd_pkg::ST_DATA: begin
          if (!data_go) begin
            st_r <= ctsd_pkg::ST_TERM;
          end else if (tag_byte_valid_i && can_emit) begin
            dcnt_r <= dcnt_r + 16'h0001;
          end
        end
        ctsd_pkg::ST_TERM: begin
          if (can_emit) st_r <= ctsd_pkg::ST_WAIT;
        end
        default: st_r <= ctsd_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmit byte register
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_valid_r <= 1'b0;
      tx_data_r  <= 8'h00;
    end else if (can_emit) begin
      tx_valid_r <= 1'b1;
      unique case (st_r)
        ctsd_pkg::ST_SHORT: tx_data_r <= short_byte;
        ctsd_pkg::ST_HEAD:  tx_data_r <= head_byte;
        ctsd_pkg::ST_DATA: begin
          tx_data_r  <= tag_byte_i;
          tx_valid_r <= data_go && tag_byte_valid_i;
        end
        ctsd_pkg::ST_TERM:  tx_data_r <= ctsd_pkg::ETX_BYTE;
        default:            tx_valid_r <= 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // out-of-range seconds timer
  wire sec_tick = (sec_cnt_r == 32'(SEC_CYCLES - 1));
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sec_cnt_r  <= 32'h0;
      away_s_r   <= 6'h00;
      last_vld_r <= 1'b0;
      last_serial_r <= 64'h0;
    end else begin
      if (tag_present_i) begin
        sec_cnt_r <= 32'h0;
        away_s_r  <= 6'h00;
      end else begin
        sec_cnt_r <= sec_tick ? 32'h0 : sec_cnt_r + 32'h1;
        if (sec_tick && away_s_r != ctsd_pkg::DELAY_MAX_S) away_s_r <= away_s_r + 6'h01;
      end
      if (st_r == ctsd_pkg::ST_TERM && can_emit) begin
        last_vld_r <= 1'b1;
        last_serial_r <= serial_r;
      end else if (!active_r || (!tag_present_i && away_s_r >= delay_r)) begin
        last_vld_r <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// *** test/ctsd_chk.sv ***
// Checker of the reply, tag read and mode ports of ctsd_top.
// Assumes one clock domain; bound into every ctsd_top.
`timescale 1ns/1ns
`default_nettype none
module ctsd_chk #(
  parameter longint SEC_CYCLES = 20,
  parameter int     MAX_PAY    = 8
) (
  input wire logic       core_clk_i,
  input wire logic       rst_n_i,
  input wire logic       tx_valid_o,
  input wire logic [7:0] tx_data_o,
  input wire logic       tx_ready_i,
  input wire logic       tag_present_i,
  input wire logic       tag_rd_req_o,
  input wire logic       cont_active_o,
  input wire logic       other_cmd_valid_o,
  input wire logic [7:0] other_cmd_code_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  //////////////////////////////
  AST_REQ_GAP: assert property (tag_rd_req_o |=> !tag_rd_req_o [*8])
    else $error("tag read request too close");
  AST_REQ_COND: assert property (tag_rd_req_o |-> cont_active_o && $past(tag_present_i))
    else $error("tag read without mode or tag");
  AST_READ_HDR: assert property (tag_rd_req_o |-> ##[0:6] tx_valid_o && tx_data_o == 8'h02)
    else $error("tag packet header missing");
  AST_OTHER_IDLE: assert property (other_cmd_valid_o |-> !$past(cont_active_o))
    else $error("command passed on in mode");
  AST_OTHER_CODE: assert property (other_cmd_valid_o |-> other_cmd_code_o != 8'h0f)
    else $error("mode command passed on");
  AST_TX_HOLD: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("reply byte dropped");
  AST_START_ACK: assert property ($rose(cont_active_o) |-> ##[0:3] tx_valid_o && tx_data_o == 8'h02)
    else $error("start not answered");
  AST_STOP_ACK: assert property ($fell(cont_active_o) |-> ##[0:3] tx_valid_o && tx_data_o == 8'h02)
    else $error("stop not answered");
  cover property ($rose(cont_active_o));
  cover property (tag_rd_req_o);
  cover property (other_cmd_valid_o);
endmodule
bind ctsd_top ctsd_chk #(.SEC_CYCLES(SEC_CYCLES), .MAX_PAY(MAX_PAY)) i_ctsd_chk (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .tx_valid_o(tx_valid_o),
  .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i), .tag_present_i(tag_present_i),
  .tag_rd_req_o(tag_rd_req_o), .cont_active_o(cont_active_o),
  .other_cmd_valid_o(other_cmd_valid_o), .other_cmd_code_o(other_cmd_code_o));
`default_nettype wire

// *** test/ctsd_host_model.sv ***
// Host model: sends framed command bytes, sinks reply bytes.
// Assumes the shared core clock; no baud timing modelled.
`timescale 1ns/1ns
`default_nettype none
module ctsd_host_model (
  input  wire logic       core_clk_i,
  input  wire logic       rx_ready_i,
  output logic            rx_valid_o,
  output logic [7:0]      rx_data_o,
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  output logic            tx_ready_o
);
  logic [7:0] got_q[$];
  logic       slow = 1'b0;
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o  = 8'h00;
    tx_ready_o = 1'b1;
  end
  //////////////////////////////
  // whole frame, hi first
  task automatic send(input logic [111:0] p, output logic hung);
    int n;
    hung = 1'b0;
    for (int k = 13; k >= 0; k--) begin
      rx_data_o  = p[8*k +: 8];
      rx_valid_o = 1'b1;
      n = 0;
      do begin
        @(posedge core_clk_i);
        n++;
      end while (rx_ready_i !== 1'b1 && n < 300);
      if (rx_ready_i !== 1'b1) hung = 1'b1;
      #1;
    end
    rx_valid_o = 1'b0;
    // Released line shows stale inverse
    rx_data_o  = ~rx_data_o;
  endtask
  always @(posedge core_clk_i) begin
    if (tx_valid_i === 1'b1 && tx_ready_o) got_q.push_back(tx_data_i);
    #1;
    tx_ready_o = slow ? ~tx_ready_o : 1'b1;
  end
endmodule
`default_nettype wire

// *** test/test_ctsd_top.sv ***
// Bench for the continuous serial-number-and-data reader.
// Assumes the host model; tag side is driven here.
`timescale 1ns/1ns
`default_nettype none
module test_ctsd_top;
  typedef logic [7:0] ctsd_q_t[$];
  typedef struct {logic [111:0] p; logic act;} ctsd_row_s;
  localparam logic [63:0] TAG_SERIAL = 64'h1e6e3dc200000001;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        tag_present = 1'b0;
  logic        tb_valid = 1'b1;
  logic [7:0]  tb_data = 8'h20;
  logic [63:0] tag_serial = TAG_SERIAL;
  logic        rx_valid, rx_ready, tx_valid, tx_ready, rd_req, tb_ready, active, oth_v;
  logic [7:0]  rx_data, tx_data, oth_c;
  logic [15:0] rd_addr, rd_len;
  int          bad_count, compares, oth, reqs;
  ctsd_q_t     ack;
  ctsd_row_s   rows[7];
  always #50 core_clk = ~core_clk;
  ctsd_top #(.SEC_CYCLES(20)) i_ctsd_top (
    .core_clk_i(core_clk), .rst_n_i(rst_n), .rx_valid_i(rx_valid), .rx_data_i(rx_data),
    .rx_ready_o(rx_ready), .tx_valid_o(tx_valid), .tx_data_o(tx_data), .tx_ready_i(tx_ready),
    .tag_present_i(tag_present), .tag_serial_number_i(tag_serial), .tag_rd_req_o(rd_req),
    .tag_rd_addr_o(rd_addr), .tag_rd_len_o(rd_len), .tag_byte_valid_i(tb_valid),
    .tag_byte_i(tb_data), .tag_byte_ready_o(tb_ready), .cont_active_o(active),
    .other_cmd_valid_o(oth_v), .other_cmd_code_o(oth_c));
  ctsd_host_model i_ctsd_host_model (
    .core_clk_i(core_clk), .rx_ready_i(rx_ready), .rx_valid_o(rx_valid),
    .rx_data_o(rx_data), .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_ready_o(tx_ready));
  always @(posedge core_clk) begin
    if (rd_req === 1'b1) reqs++;
    if (oth_v === 1'b1) oth++;
  end
  // Tag bytes count up from 20h
  always @(posedge core_clk) if (tb_ready === 1'b1) #1 tb_data <= tb_data + 8'h01;
  //////////////////////////////
  task automatic finish_test();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic host(input logic [111:0] p);
    logic hung;
    i_ctsd_host_model.send(p, hung);
    if (hung) begin
      bad_count++;
      finish_test();
    end
  endtask
  task automatic expect_pkt(input ctsd_q_t e);
    int n;
    n = 0;
    // Always let one edge pass so stimulus keeps the same offset
    do begin
      @(posedge core_clk);
      n++;
    end while (i_ctsd_host_model.got_q.size() < e.size() && n < 3000);
    #1;
    if (i_ctsd_host_model.got_q.size() < e.size()) begin
      bad_count++;
      finish_test();
    end
    foreach (e[k]) check(i_ctsd_host_model.got_q.pop_front(), e[k]);
  endtask
  function automatic ctsd_q_t tagpkt(input int len);
    ctsd_q_t q;
    q = '{8'h02, 8'h02, 8'h00, 8'(9 + len), 8'h0e};
    for (int k = 7; k >= 0; k--) q.push_back(TAG_SERIAL[8*k +: 8]);
    for (int k = 0; k < len; k++) q.push_back(8'(32 + k));
    q.push_back(8'h03);
    return q;
  endfunction
  function automatic logic [111:0] cmd(input logic [15:0] len, input logic [7:0] dly,
                                       input logic [7:0] ss, input logic [23:0] tail);
    return {32'h0202_0007, 8'h0f, 16'h0005, len, dly, ss, tail};
  endfunction
  //////////////////////////////
  initial begin
    ack = '{8'h02, 8'h02, 8'h00, 8'h01, 8'h0f, 8'h03};
    rows = '{'{cmd(2, 2, 1, 24'h035555), 1'b1},
             '{112'h0202_0001_0e03_5555_5555_5555_5555, 1'b1},
             '{cmd(2, 2, 0, 24'h035555), 1'b0}, '{cmd(2, 2, 0, 24'ha5ffff), 1'b0},
             '{cmd(2, 2, 1, 24'ha5ffff), 1'b1}, '{cmd(2, 2, 1, 24'h035555), 1'b1},
             '{cmd(2, 2, 0, 24'h035555), 1'b0}};
    repeat (5) @(posedge core_clk);
    check({rx_ready, tx_valid, active, rd_req}, 4'h8);
    #1 rst_n = 1'b1;
    tick(1);
    foreach (rows[i]) begin
      host(rows[i].p);
      expect_pkt(ack);
      check(active, rows[i].act);
    end
    check(oth, 0);
    tag_present = 1'b1;
    tick(20);
    check(reqs, 0);
    i_ctsd_host_model.slow = 1'b1;
    host(cmd(2, 2, 1, 24'h035555));
    expect_pkt(ack);
    expect_pkt(tagpkt(2));
    check({rd_addr, rd_len}, 32'h0005_0002);
    tick(50);
    tag_present = 1'b0;
    tick(30);
    tag_present = 1'b1;
    tick(10);
    check(reqs, 1);
    tag_present = 1'b0;
    tb_data = 8'h20;
    tick(50);
    tag_present = 1'b1;
    expect_pkt(tagpkt(2));
    host(cmd(0, 0, 1, 24'h035555));
    expect_pkt(ack);
    expect_pkt(tagpkt(0));
    expect_pkt(tagpkt(0));
    tag_present = 1'b0;
    tick(60);
    i_ctsd_host_model.got_q.delete();
    host(cmd(0, 0, 0, 24'h035555));
    expect_pkt(ack);
    host(112'h0202_0001_0e77_ffff_5555_5555_5555);
    tick(20);
    check({oth_c, 24'(oth), 8'(i_ctsd_host_model.got_q.size())}, 40'h0e00_0001_00);
    finish_test();
  end
endmodule
`default_nettype wire
